/* File: hw/ptc_defines.svh */
/*
 * register map, field positions, reset values and widths of the timer
 * assumes: included by bare name from the package and design modules
 */
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH

`define PTC_ADDR_CTRL      8'h00
`define PTC_ADDR_CNT       8'h04
`define PTC_ADDR_STATUS    8'h08
`define PTC_ADDR_CLEAR     8'h0c
`define PTC_ADDR_ENABLE    8'h10

`define PTC_CTRL_RESET     8'hff
`define PTC_BIT_RUN        7
`define PTC_BIT_WIDTH8     6
`define PTC_BIT_SRC        5
`define PTC_BIT_EDGE       4
`define PTC_BIT_BYPASS     3
`define PTC_RATIO_MSB      2
`define PTC_RATIO_LSB      0

`define PTC_BIT_OVF        0
`define PTC_CNT_RESET      16'h0000
`define PTC_PRE_BITS       8

`endif

/* File: hw/ptc_pin_sync.sv */
/*
 * two-flop synchroniser and edge detector for the external count pin
 * assumes: pin is asynchronous to the core clock
 */
`timescale 1ns/1ns

module ptc_pin_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    input  wire logic falling_i,
    output logic      edge_o
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic last_q, last_d;

    always_comb begin
        meta_d = pin_i;
        sync_d = meta_q;
        last_d = sync_q;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    // only the second flop and its delayed copy feed the edge logic
    assign edge_o = falling_i ? (last_q & ~sync_q)
                              : (~last_q & sync_q);
endmodule

/* File: hw/ptc_pkg.sv */
/*
 * types shared by the timer modules
 * assumes: ptc_defines.svh defines the widths used here
 */
`include "ptc_defines.svh"

package ptc_pkg;
    typedef logic [`PTC_PRE_BITS-1:0] ptc_pre_t;
    typedef logic [15:0]              ptc_cnt_t;
    typedef enum logic [2:0] {
        PTC_BUS_IDLE  = 3'b001,
        PTC_BUS_WRESP = 3'b010,
        PTC_BUS_RDATA = 3'b100
    } ptc_bus_state_t;
endpackage

/* File: hw/ptc_prescaler.sv */
/*
 * power-of-two prescaler: pulse out once per 2^(ratio+1) input ticks
 * assumes: tick_i is a one-cycle enable on the core clock
 */
`timescale 1ns/1ns
`include "ptc_defines.svh"

module ptc_prescaler #(
    parameter int PRE_BITS = `PTC_PRE_BITS
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clear_i,
    input  wire logic       tick_i,
    input  wire logic [2:0] ratio_i,
    output logic            tick_o
);
    logic [PRE_BITS-1:0] cnt_q, cnt_d;
    logic [PRE_BITS-1:0] mask;

    // ratio 0 divides by 2, ratio 7 by 256
    assign mask = PRE_BITS'((9'h002 << ratio_i) - 9'h001);

    always_comb begin
        cnt_d = cnt_q;
        if (clear_i) begin
            cnt_d = '0;
        end else if (tick_i) begin
            cnt_d = (cnt_q & mask) == mask ? '0 : cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign tick_o = tick_i & ~clear_i & ((cnt_q & mask) == mask);
endmodule

/* File: hw/ptc_timer.sv */
/*
 * prescaled 8/16-bit timer/counter with AXI4-Lite register slave
 * assumes: single core clock, synchronous active-low reset, AXI4-Lite
 * master obeying the protocol (one write and one read outstanding)
 */
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`include "ptc_defines.svh"

module ptc_timer (
    input  wire logic        CORE_CLK_I,
    input  wire logic        RESET_N_I,
    input  wire logic        COUNT_PIN_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [7:0]  S_AXI_AWADDR_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    output logic [1:0]       S_AXI_BRESP_O,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    input  wire logic [7:0]  S_AXI_ARADDR_I,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             IRQ_O
);
    logic [7:0]        ctrl_q, ctrl_d;
    ptc_pkg::ptc_cnt_t cnt_q, cnt_d;
    logic              ovf_q, ovf_d;
    logic              ien_q, ien_d;

    ptc_pkg::ptc_bus_state_t wst_q, wst_d;
    logic              aw_q, aw_d;
    logic              w_q, w_d;
    logic [7:0]        waddr_q, waddr_d;
    logic [31:0]       wdata_q, wdata_d;
    logic [3:0]        wstrb_q, wstrb_d;
    logic              bresp_err_q, bresp_err_d;

    ptc_pkg::ptc_bus_state_t rst_q, rst_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              rresp_err_q, rresp_err_d;

    logic pin_edge;
    logic src_tick;
    logic pre_tick;
    logic cnt_tick;
    logic wrap;
    logic wr_fire;
    logic pre_clear;

    wire run    = ctrl_q[`PTC_BIT_RUN];
    wire width8 = ctrl_q[`PTC_BIT_WIDTH8];
    wire ext    = ctrl_q[`PTC_BIT_SRC];
    wire bypass = ctrl_q[`PTC_BIT_BYPASS];

    ptc_pin_sync u_sync (
        .clk_i     (CORE_CLK_I),
        .rst_n_i   (RESET_N_I),
        .pin_i     (COUNT_PIN_I),
        .falling_i (ctrl_q[`PTC_BIT_EDGE]),
        .edge_o    (pin_edge)
    );

    // internal source ticks every core cycle; run gates both sources
    assign src_tick = run & (ext ? pin_edge : 1'b1);

    // writing control or counter restarts the prescale count
    assign pre_clear = wr_fire & (waddr_q == `PTC_ADDR_CTRL
                                  || waddr_q == `PTC_ADDR_CNT);

    ptc_prescaler u_pre (
        .clk_i   (CORE_CLK_I),
        .rst_n_i (RESET_N_I),
        .clear_i (pre_clear),
        .tick_i  (src_tick & ~bypass),
        .ratio_i (ctrl_q[`PTC_RATIO_MSB:`PTC_RATIO_LSB]),
        .tick_o  (pre_tick)
    );

    assign cnt_tick = bypass ? src_tick : pre_tick;
    assign wrap = cnt_tick & (width8 ? (cnt_q[7:0] == 8'hff)
                                     : (cnt_q == 16'hffff));

    // write channel: address and data taken independently, in any order
    assign S_AXI_AWREADY_O = (wst_q == ptc_pkg::PTC_BUS_IDLE) & ~aw_q;
    assign S_AXI_WREADY_O  = (wst_q == ptc_pkg::PTC_BUS_IDLE) & ~w_q;
    assign wr_fire = (wst_q == ptc_pkg::PTC_BUS_IDLE) & aw_q & w_q;

    always_comb begin
        wst_d = wst_q;
        aw_d = aw_q;
        w_d = w_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bresp_err_d = bresp_err_q;
        if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_d = 1'b1;
            waddr_d = {S_AXI_AWADDR_I[7:2], 2'b00};
        end
        if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_d = 1'b1;
            wdata_d = S_AXI_WDATA_I;
            wstrb_d = S_AXI_WSTRB_I;
        end
        case (wst_q)
            ptc_pkg::PTC_BUS_IDLE: begin
                if (wr_fire) begin
                    aw_d = 1'b0;
                    w_d = 1'b0;
                    bresp_err_d = !(waddr_q == `PTC_ADDR_CTRL
                                 || waddr_q == `PTC_ADDR_CNT
                                 || waddr_q == `PTC_ADDR_STATUS
                                 || waddr_q == `PTC_ADDR_CLEAR
                                 || waddr_q == `PTC_ADDR_ENABLE);
                    wst_d = ptc_pkg::PTC_BUS_WRESP;
                end
            end
            ptc_pkg::PTC_BUS_WRESP: begin
                if (S_AXI_BREADY_I) begin
                    wst_d = ptc_pkg::PTC_BUS_IDLE;
                end
            end
            default: begin
                wst_d = ptc_pkg::PTC_BUS_IDLE;
            end
        endcase
    end

    // register file and counter next state
    always_comb begin
        ctrl_d = ctrl_q;
        cnt_d = cnt_q;
        ovf_d = ovf_q;
        ien_d = ien_q;
        if (cnt_tick) begin
            cnt_d = width8 ? {cnt_q[15:8], cnt_q[7:0] + 8'h01}
                           : cnt_q + 16'h0001;
        end
        if (wr_fire && wstrb_q[0]) begin
            case (waddr_q)
                `PTC_ADDR_CTRL:   ctrl_d = wdata_q[7:0];
                `PTC_ADDR_CNT:    cnt_d[7:0] = wdata_q[7:0];
                `PTC_ADDR_CLEAR: begin
                    if (wdata_q[`PTC_BIT_OVF]) begin
                        ovf_d = 1'b0;
                    end
                end
                `PTC_ADDR_ENABLE: ien_d = wdata_q[`PTC_BIT_OVF];
                default: ;
            endcase
        end
        if (wr_fire && wstrb_q[1] && waddr_q == `PTC_ADDR_CNT) begin
            cnt_d[15:8] = wdata_q[15:8];
        end
        // a wrap in the clearing cycle still sets the flag
        if (wrap) begin
            ovf_d = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            ctrl_q <= `PTC_CTRL_RESET;
            cnt_q <= `PTC_CNT_RESET;
            ovf_q <= 1'b0;
            ien_q <= 1'b0;
            wst_q <= ptc_pkg::PTC_BUS_IDLE;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_err_q <= 1'b0;
            rst_q <= ptc_pkg::PTC_BUS_IDLE;
            rdata_q <= 32'h0000_0000;
            rresp_err_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
            ien_q <= ien_d;
            wst_q <= wst_d;
            aw_q <= aw_d;
            w_q <= w_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bresp_err_q <= bresp_err_d;
            rst_q <= rst_d;
            rdata_q <= rdata_d;
            rresp_err_q <= rresp_err_d;
        end
    end

    assign S_AXI_BVALID_O = (wst_q == ptc_pkg::PTC_BUS_WRESP);
    assign S_AXI_BRESP_O  = bresp_err_q ? 2'h2 : 2'h0;

    // read channel
    assign S_AXI_ARREADY_O = (rst_q == ptc_pkg::PTC_BUS_IDLE);

    always_comb begin
        rst_d = rst_q;
        rdata_d = rdata_q;
        rresp_err_d = rresp_err_q;
        case (rst_q)
            ptc_pkg::PTC_BUS_IDLE: begin
                if (S_AXI_ARVALID_I) begin
                    rresp_err_d = 1'b0;
                    rst_d = ptc_pkg::PTC_BUS_RDATA;
                    case ({S_AXI_ARADDR_I[7:2], 2'b00})
                        `PTC_ADDR_CTRL:   rdata_d = {24'h0, ctrl_q};
                        `PTC_ADDR_CNT:    rdata_d = {16'h0, cnt_q};
                        `PTC_ADDR_STATUS: rdata_d = {31'h0, ovf_q};
                        `PTC_ADDR_CLEAR:  rdata_d = 32'h0000_0000;
                        `PTC_ADDR_ENABLE: rdata_d = {31'h0, ien_q};
                        default: begin
                            rdata_d = 32'h0000_0000;
                            rresp_err_d = 1'b1;
                        end
                    endcase
                end
            end
            ptc_pkg::PTC_BUS_RDATA: begin
                if (S_AXI_RREADY_I) begin
                    rst_d = ptc_pkg::PTC_BUS_IDLE;
                end
            end
            default: begin
                rst_d = ptc_pkg::PTC_BUS_IDLE;
            end
        endcase
    end

    assign S_AXI_RVALID_O = (rst_q == ptc_pkg::PTC_BUS_RDATA);
    assign S_AXI_RDATA_O  = rdata_q;
    assign S_AXI_RRESP_O  = rresp_err_q ? 2'h2 : 2'h0;
    assign IRQ_O = ovf_q & ien_q;

    property p_stop;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (!run && !wr_fire) |=> cnt_q == $past(cnt_q);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");

    property p_w8;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (width8 && cnt_tick && !wr_fire) |=> cnt_q[15:8] == $past(cnt_q[15:8]);
    endproperty
    a_w8: assert property (p_w8) else $error("upper byte moved in 8-bit mode");

    property p_int;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (run && !ext && bypass && !wr_fire) |=> cnt_tick;
    endproperty
    a_int: assert property (p_int) else $error("internal tick missing");

    property p_edge;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (ext && cnt_tick) |-> pin_edge;
    endproperty
    a_edge: assert property (p_edge) else $error("count without pin edge");

    property p_bypass;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (!bypass && cnt_tick) |-> pre_tick;
    endproperty
    a_bypass: assert property (p_bypass) else $error("prescaler bypassed");

    property p_div2;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (!bypass && pre_tick && src_tick
         && ctrl_q[`PTC_RATIO_MSB:`PTC_RATIO_LSB] == 3'h0 && !pre_clear)
        |=> !pre_tick;
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two broken");

    property p_wcnt;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        (wr_fire && waddr_q == `PTC_ADDR_CNT && wstrb_q == 4'hf)
        |=> cnt_q == $past(wdata_q[15:0]);
    endproperty
    a_wcnt: assert property (p_wcnt) else $error("counter preload lost");

    property p_ovf;
        @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
        wrap |=> ovf_q && cnt_q[7:0] == 8'h00 || $past(wr_fire);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");
endmodule

/* File: verif/ptc_pulse_src.sv */
/*
 * pulse source standing on the external count pin of the timer
 * assumes: started from the bench on the core clock; the pin keeps its
 * last level between bursts, as a real pulse generator would
 */
`timescale 1ns/1ns

module ptc_pulse_src (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [11:0] toggles_i,
    input  wire logic        slow_i,
    output logic             pin_o,
    output logic             busy_o
);
    logic [11:0] left_q;
    logic [2:0]  hold_q;
    logic        slow_q;

    initial begin
        pin_o  = 1'b0;
        left_q = 12'h000;
        hold_q = 3'h0;
        slow_q = 1'b0;
    end
    assign busy_o = (left_q != 12'h000);

    // each level lasts at least 2 clocks, else the synchroniser may miss it
    always @(posedge clk_i) begin
        if (go_i && !busy_o) begin
            left_q <= toggles_i;
            slow_q <= slow_i;
            hold_q <= slow_i ? 3'h5 : 3'h2;
        end else if (busy_o) begin
            if (hold_q > 3'h1) begin
                hold_q <= hold_q - 3'h1;
            end else begin
                pin_o  <= ~pin_o;
                left_q <= left_q - 12'h001;
                hold_q <= slow_q ? 3'h5 : 3'h2;
            end
        end
    end
endmodule

/* File: verif/ptc_timer_tb_top.sv */
/*
 * self-checking bench of the timer: AXI4-Lite master, pin pulse source
 * assumes: design and ptc_pulse_src compiled before; 250 MHz core clock
 */
`timescale 1ns/1ns
`include "ptc_defines.svh"

module ptc_timer_tb_top;
    localparam logic [7:0] a_ctl = `PTC_ADDR_CTRL;
    localparam logic [7:0] a_cnt = `PTC_ADDR_CNT;
    localparam logic [7:0] a_st  = `PTC_ADDR_STATUS;
    localparam logic [7:0] a_clr = `PTC_ADDR_CLEAR;
    localparam logic [7:0] a_en  = `PTC_ADDR_ENABLE;
    localparam logic [7:0] k_run = 8'h01 << `PTC_BIT_RUN;
    localparam logic [7:0] k_w8  = 8'h01 << `PTC_BIT_WIDTH8;
    localparam logic [7:0] k_src = 8'h01 << `PTC_BIT_SRC;
    localparam logic [7:0] k_fal = 8'h01 << `PTC_BIT_EDGE;
    localparam logic [7:0] k_byp = 8'h01 << `PTC_BIT_BYPASS;

    logic        clk, rst_n, pin, busy, go, slow, irq;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, r_data, d;
    logic [3:0]  wstrb;
    logic [1:0]  b_resp, r_resp, r;
    logic [11:0] toggles;
    logic [31:0] seed, v;
    int          n_errors, checked, cycles, k, ev;

    ptc_timer dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .COUNT_PIN_I(pin),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(aw_rdy),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(w_rdy), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
        .S_AXI_BVALID_O(b_vld), .S_AXI_BREADY_I(bready),
        .S_AXI_BRESP_O(b_resp), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(ar_rdy), .S_AXI_ARADDR_I(araddr),
        .S_AXI_RVALID_O(r_vld), .S_AXI_RREADY_I(rready),
        .S_AXI_RDATA_O(r_data), .S_AXI_RRESP_O(r_resp), .IRQ_O(irq));
    ptc_pulse_src src (.clk_i(clk), .go_i(go), .toggles_i(toggles),
        .slow_i(slow), .pin_o(pin), .busy_o(busy));

    always #2 clk = ~clk;

    function automatic logic [31:0] pre_exp(input int e, input int q);
        return 32'(e >> (q + 1));
    endfunction
    function automatic logic [31:0] edge_exp(input int n, input int fall);
        return 32'(fall ? n : n + 1);
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // sample at the falling edge: inputs only move just after rising edges
    task automatic wr(input logic [7:0] a, input logic [31:0] dd,
                      input logic [3:0] s, output logic [1:0] rr);
        logic ah, wh, bh;
        bh = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= dd;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bh) begin
            @(negedge clk);
            ah = awvalid && aw_rdy;
            wh = wvalid && w_rdy;
            bh = b_vld;
            rr = b_resp;
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dd,
                      output logic [1:0] rr);
        logic ah, rh;
        rh = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rh) begin
            @(negedge clk);
            ah = arvalid && ar_rdy;
            rh = r_vld;
            dd = r_data;
            rr = r_resp;
            @(posedge clk);
            if (ah) arvalid <= 1'b0;
            if (rh) rready <= 1'b0;
        end
    endtask
    task automatic wok(input logic [7:0] a, input logic [31:0] dd);
        wr(a, dd, 4'hf, r);
        chk(32'(r), 32'h0);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk(32'(r), 32'h0);
        chk(d, exp);
    endtask
    task automatic pulses(input int n);
        @(posedge clk);
        v = $random(seed);
        toggles <= n[11:0];
        slow <= v[0];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        while (busy) @(negedge clk);
        repeat (8) @(posedge clk);
    endtask
    task automatic irq_is(input logic exp);
        repeat (3) @(negedge clk);
        chk(32'(irq), 32'(exp));
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            $display("BAD %0t run hung", $time);
            tally_and_finish();
        end
    end

    initial begin
        seed = 32'h3bac6010;
        {clk, rst_n, go, slow, awvalid, wvalid, bready, arvalid} = '0;
        {rready, awaddr, araddr, wdata, toggles} = '0;
        wstrb = 4'hf;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdc(a_ctl, 32'hff);
        rdc(a_cnt, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wok(a_ctl, {25'h0, v[6:0]});
            rdc(a_ctl, {25'h0, v[6:0]});
            wok(a_cnt, v);
            // lane 0 only: the upper byte keeps what the full write left
            wr(a_cnt, 32'hffffffa5, 4'h1, r);
            chk(32'(r), 32'h0);
            rdc(a_cnt, {16'h0, v[15:8], 8'ha5});
        end
        wr(8'h14, 32'h1, 4'hf, r);
        chk(32'(r), 32'h2);
        rd(8'h14, d, r);
        chk({d[29:0], r}, 32'h2);
        $display("test register access done");
        wok(a_ctl, 0);
        wok(a_cnt, 0);
        wok(a_ctl, k_run | k_byp);
        repeat (100) @(posedge clk);
        wok(a_ctl, k_byp);
        rd(a_cnt, v, r);
        chk(32'(v >= 100 && v <= 112), 32'h1);
        repeat (20) @(posedge clk);
        rdc(a_cnt, v);
        $display("test internal clock done");
        for (int e = 0; e < 2; e++) begin
            v = $random(seed);
            k = int'(v[3:0]) + 1;
            wok(a_ctl, 0);
            wok(a_cnt, 0);
            wok(a_ctl, k_run | k_src | k_byp | (e != 0 ? k_fal : 8'h00));
            pulses(2 * k + 1);
            rdc(a_cnt, edge_exp(k, e));
            wok(a_ctl, 0);
            pulses(1);
        end
        $display("test edge select done");
        for (int q = 0; q < 8; q++) begin
            ev = (4 << (q + 1)) - 1;
            wok(a_ctl, 0);
            wok(a_cnt, 0);
            wok(a_ctl, k_run | k_src | 8'(q));
            pulses(2 * ev);
            rdc(a_cnt, pre_exp(ev, q));
        end
        $display("test prescaler done");
        wok(a_ctl, 0);
        wok(a_en, 1);
        wok(a_cnt, 32'h12fe);
        wok(a_clr, 1);
        wok(a_ctl, k_run | k_w8 | k_src | k_byp);
        pulses(2);
        rdc(a_cnt, 32'h12ff);
        rdc(a_st, 0);
        pulses(2);
        rdc(a_cnt, 32'h1200);
        rdc(a_st, 1);
        irq_is(1'b1);
        wok(a_en, 0);
        irq_is(1'b0);
        rdc(a_en, 0);
        wok(a_en, 1);
        irq_is(1'b1);
        rdc(a_en, 1);
        wok(a_clr, 1);
        irq_is(1'b0);
        rdc(a_st, 0);
        wok(a_ctl, 0);
        wok(a_cnt, 32'h00fe);
        wok(a_ctl, k_run | k_src | k_byp);
        pulses(4);
        rdc(a_cnt, 32'h0100);
        rdc(a_st, 0);
        wok(a_ctl, 0);
        wok(a_cnt, 32'hffff);
        wok(a_ctl, k_run | k_src | k_byp);
        pulses(2);
        rdc(a_cnt, 0);
        rdc(a_st, 1);
        $display("test overflow done");
        tally_and_finish();
    end
endmodule
